/* hdl/ive_entry.sv */
// Interrupt recognition, register stacking, vector fetch and return unit
//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// (RULE1) 20 vectors, 32 sources, 17 maskable peripheral requests
// (RULE2) Maskable requests, IRQ included, need I clear
// (RULE3) NMI pin, trap, illegal ignore I; NMI needs X
// (RULE4) Software trap FFF6, illegal opcode FFF8, unmasked
// (RULE5) Watchdog FFFA, clock monitor FFFC, reset FFFE
// (RULE6) Recognized when enabled; serviced at instruction end
// (RULE7) Push nine bytes downward, CONDITION_CODE_REG last at SP-8
// (RULE8) Set I after CONDITION_CODE_REG stacked; X for NMI
// (RULE9) Fetch winner's two-byte vector, continue there
// (RULE10) Return pulls bytes in reverse stacking order
// (RULE11) Receive-full clears on status then data read
// (RULE12) Channel 3 sources share FFD2 under enables
// (RULE13) Channel 2 sources share FFD4 under enables
// (RULE14) Channel 1 sources share FFD6 under enables
// (RULE15) Sync serial completion at FFD8, own enable
// (RULE16) Pulse edge FFDA, pulse overflow FFDC
// (RULE17) Timer overflow FFDE, capture4/compare5 FFE0
// (RULE18) Compare 4..1 at FFE2 down to FFE8
// (RULE19) Capture 3..1 FFEA..FFEE, periodic tick FFF0
// (RULE20) Vector high byte even; low table reserved
// (RULE21) Fixed default priority; one source promotable
// (RULE22) Reset sets X and I; software never re-sets X
//////////////////////////////////////////////////////////////////////////////
module ive_entry
  import ive_pkg::*;
(
  input  wire logic          core_clk_in,
  input  wire logic          nrst_in,
  input  wire ive_flags_t    flags_in,
  input  wire ive_enables_t  enables_in,
  input  wire logic [2:0]    rx_status_rd_in,
  input  wire logic [2:0]    rx_data_rd_in,
  input  wire logic          nonmaskable_req_pin_in,
  input  wire logic          watchdog_fail_in,
  input  wire logic          clock_fail_in,
  input  wire logic          instr_done_in,
  input  wire logic          software_trap_in,
  input  wire logic          illegal_opcode_in,
  input  wire logic          return_in,
  input  wire ive_cpu_regs_t cpu_regs_in,
  input  wire logic [15:0]   sp_in,
  input  wire logic [7:0]    mem_rdata_in,
  input  wire logic [7:0]    reg_addr_in,
  input  wire logic [7:0]    reg_wdata_in,
  input  wire logic          reg_wr_in,
  input  wire logic          reg_rd_in,
  output logic [7:0]         reg_rdata_out,
  output logic [15:0]        mem_addr_out,
  output logic [7:0]         mem_wdata_out,
  output logic               mem_we_out,
  output logic               mem_re_out,
  output logic               busy_out,
  output logic               pc_load_out,
  output logic [15:0]        pc_value_out,
  output logic               restore_valid_out,
  output ive_cpu_regs_t      restore_regs_out,
  output logic [15:0]        sp_out,
  output logic [7:0]         condition_code_reg_out,
  output logic [2:0]         receive_full_flag_out
);

  typedef struct packed {
    ive_state_t    fsm;
    logic [3:0]    cnt;
    logic [15:0]   vec;
    logic          set_x;
    ive_cpu_regs_t regs;
    logic [15:0]   sp;
    logic [7:0]    condition_code_reg;
    logic [4:0]    psel;
    logic [2:0]    rx_full;
    logic [2:0]    rx_armed;
    logic [7:0]    rdata;
    logic [15:0]   mem_addr;
    logic [7:0]    mem_wdata;
    logic          mem_we;
    logic          mem_re;
    logic          pc_load;
    logic [15:0]   pc_val;
    logic          restore_valid;
    ive_cpu_regs_t restore;
    logic          busy;
  } ive_core_t;

  ive_core_t s;
  ive_core_t next_s;

  // Byte k of the stacking order: PROG_COUNTER_LOW first, CONDITION_CODE_REG last
  function automatic logic [7:0] stack_byte(ive_cpu_regs_t r, logic [7:0] c, logic [3:0] k);
    case (k)
      4'h0:    stack_byte = r.pc[7:0];
      4'h1:    stack_byte = r.pc[15:8];
      4'h2:    stack_byte = r.iy[7:0];
      4'h3:    stack_byte = r.iy[15:8];
      4'h4:    stack_byte = r.ix[7:0];
      4'h5:    stack_byte = r.ix[15:8];
      4'h6:    stack_byte = r.acc_a;
      4'h7:    stack_byte = r.acc_b;
      default: stack_byte = c;
    endcase
  endfunction

  function automatic ive_cpu_regs_t put_byte(ive_cpu_regs_t r, logic [3:0] k, logic [7:0] d);
    put_byte = r;
    case (k)
      4'h0:    put_byte.pc[7:0]   = d;
      4'h1:    put_byte.pc[15:8]  = d;
      4'h2:    put_byte.iy[7:0]   = d;
      4'h3:    put_byte.iy[15:8]  = d;
      4'h4:    put_byte.ix[7:0]   = d;
      4'h5:    put_byte.ix[15:8]  = d;
      4'h6:    put_byte.acc_a     = d;
      4'h7:    put_byte.acc_b     = d;
      default: put_byte           = r;
    endcase
  endfunction

  // Reserved select codes fall back to the external level request
  function automatic logic [4:0] psel_index(logic [4:0] code);
    if (code >= IVE_PSEL_FIRST && code <= IVE_PSEL_LAST) begin
      psel_index = 5'(code - IVE_PSEL_FIRST);
    end else begin
      psel_index = 5'h00;
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Request gating
  logic [IVE_NUM_MASKABLE-1:0] pend;
  logic [2:0]                  sci_req;
  logic [4:0]                  win;
  logic                        any_pend;
  logic                        wd_hit;
  logic                        cm_hit;
  logic                        nmi_ok;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sci
      // Channels 1..3 feed FFD6, FFD4, FFD2
      assign sci_req[gi] =
        ((s.rx_full[gi] | flags_in.sci[gi].overrun) & enables_in.sci[gi].receive_irq_en) |
        (flags_in.sci[gi].tx_empty & enables_in.sci[gi].tx_empty_irq_en) |
        (flags_in.sci[gi].tx_complete & enables_in.sci[gi].tx_complete_irq_en) |
        (flags_in.sci[gi].idle_line & enables_in.sci[gi].idle_irq_en); // RULE12 RULE13 RULE14
    end
  endgenerate

  always_comb begin
    pend[0]  = flags_in.irq_level;                                       // RULE2
    pend[1]  = flags_in.periodic_tick & enables_in.periodic_tick_irq_en;  // RULE19
    pend[2]  = flags_in.capture[0] & enables_in.capture1_irq_en;         // RULE19
    pend[3]  = flags_in.capture[1] & enables_in.capture2_irq_en;         // RULE19
    pend[4]  = flags_in.capture[2] & enables_in.capture3_irq_en;         // RULE19
    pend[5]  = flags_in.compare[0] & enables_in.compare1_irq_en;         // RULE18
    pend[6]  = flags_in.compare[1] & enables_in.compare2_irq_en;         // RULE18
    pend[7]  = flags_in.compare[2] & enables_in.compare3_irq_en;         // RULE18
    pend[8]  = flags_in.compare[3] & enables_in.compare4_irq_en;         // RULE18
    pend[9]  = flags_in.capture4_compare5 & enables_in.capture4_compare5_irq_en; // RULE17
    pend[10] = flags_in.timer_overflow & enables_in.timer_overflow_irq_en;      // RULE17
    pend[11] = flags_in.pulse_overflow & enables_in.pulse_overflow_irq_en;      // RULE16
    pend[12] = flags_in.pulse_edge & enables_in.pulse_edge_irq_en;              // RULE16
    pend[13] = flags_in.sync_serial & enables_in.sync_serial_irq_en;            // RULE15
    pend[14] = sci_req[0];
    pend[15] = sci_req[1];
    pend[16] = sci_req[2];
    any_pend = |pend;
    // Promoted source wins only if it is itself pending
    win = IVE_DEFAULT_ORDER[0];
    for (int k = IVE_NUM_MASKABLE - 1; k >= 0; k--) begin
      if (pend[IVE_DEFAULT_ORDER[k]]) begin
        win = IVE_DEFAULT_ORDER[k];
      end
    end
    if (pend[psel_index(s.psel)]) begin
      win = psel_index(s.psel); // RULE21
    end
    wd_hit = watchdog_fail_in & ~enables_in.watchdog_disable; // RULE5
    cm_hit = clock_fail_in & enables_in.clock_monitor_en;     // RULE5
    nmi_ok = nonmaskable_req_pin_in & ~s.condition_code_reg[IVE_CCR_X];      // RULE3
  end

  //////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    next_s               = s;
    next_s.mem_we        = 1'b0;
    next_s.mem_re        = 1'b0;
    next_s.pc_load       = 1'b0;
    next_s.restore_valid = 1'b0;

    // Receive-full flags: a new arrival beats a clearing read
    for (int c = 0; c < 3; c++) begin
      if (flags_in.sci[c].rx_full) begin
        next_s.rx_full[c] = 1'b1;
      end else if (s.rx_armed[c] && rx_data_rd_in[c]) begin
        next_s.rx_full[c]  = 1'b0; // RULE11
        next_s.rx_armed[c] = 1'b0;
      end
      if (rx_status_rd_in[c] && s.rx_full[c]) begin
        next_s.rx_armed[c] = 1'b1; // RULE11
      end
    end

    // Software port
    if (reg_rd_in) begin
      case (reg_addr_in)
        IVE_REG_PRIO:   next_s.rdata = {3'h0, s.psel};
        IVE_REG_CCR:    next_s.rdata = s.condition_code_reg;
        IVE_REG_PEND:   next_s.rdata = {any_pend, 2'h0, win};
        IVE_REG_RXFULL: next_s.rdata = {5'h00, s.rx_full};
        default:        next_s.rdata = 8'h00;
      endcase
    end
    if (reg_wr_in && reg_addr_in == IVE_REG_PRIO && s.condition_code_reg[IVE_CCR_I]) begin
      next_s.psel = reg_wdata_in[4:0]; // RULE21
    end
    if (reg_wr_in && reg_addr_in == IVE_REG_CCR && s.fsm == IVE_ST_IDLE) begin
      next_s.condition_code_reg = reg_wdata_in;
      next_s.condition_code_reg[IVE_CCR_X] = reg_wdata_in[IVE_CCR_X] & s.condition_code_reg[IVE_CCR_X]; // RULE22
    end

    case (s.fsm)
      IVE_ST_IDLE: begin
        next_s.cnt   = 4'h0;
        next_s.set_x = 1'b0;
        // Reset-type sources skip stacking and mask everything
        if (cm_hit || wd_hit) begin
          next_s.vec = cm_hit ? IVE_VEC_CLKMON : IVE_VEC_WATCHDOG; // RULE5
          next_s.condition_code_reg[IVE_CCR_X] = 1'b1;
          next_s.condition_code_reg[IVE_CCR_I] = 1'b1;
          next_s.fsm = IVE_ST_VEC;
        end else if (instr_done_in) begin // RULE6
          next_s.regs = cpu_regs_in;
          next_s.sp   = sp_in;
          if (return_in) begin
            next_s.restore = cpu_regs_in;
            next_s.fsm     = IVE_ST_PULL; // RULE10
          end else if (nmi_ok) begin
            next_s.vec   = IVE_VEC_NMI; // RULE3
            next_s.set_x = 1'b1;
            next_s.fsm   = IVE_ST_STACK;
          end else if (illegal_opcode_in) begin
            next_s.vec = IVE_VEC_ILLEGAL; // RULE4
            next_s.fsm = IVE_ST_STACK;
          end else if (software_trap_in) begin
            next_s.vec = IVE_VEC_SWTRAP; // RULE4
            next_s.fsm = IVE_ST_STACK;
          end else if (any_pend && !s.condition_code_reg[IVE_CCR_I]) begin
            next_s.vec = IVE_VEC_TABLE[win]; // RULE2 RULE1
            next_s.fsm = IVE_ST_STACK;
          end
        end
      end
      IVE_ST_STACK: begin
        next_s.mem_we    = 1'b1;
        next_s.mem_addr  = 16'(s.sp - {12'h000, s.cnt}); // RULE7
        next_s.mem_wdata = stack_byte(s.regs, s.condition_code_reg, s.cnt); // RULE7
        next_s.cnt       = 4'(s.cnt + 4'h1);
        if (s.cnt == IVE_STACK_LAST) begin
          next_s.condition_code_reg[IVE_CCR_I] = 1'b1; // RULE8
          if (s.set_x) begin
            next_s.condition_code_reg[IVE_CCR_X] = 1'b1; // RULE8
          end
          next_s.sp  = 16'(s.sp - IVE_STACK_SPAN);
          next_s.cnt = 4'h0;
          next_s.fsm = IVE_ST_VEC;
        end
      end
      IVE_ST_VEC: begin
        // High byte sits at the even address
        next_s.cnt = 4'(s.cnt + 4'h1);
        if (s.cnt == 4'h0) begin
          next_s.mem_re   = 1'b1;
          next_s.mem_addr = s.vec; // RULE20 RULE9
        end else if (s.cnt == 4'h1) begin
          next_s.mem_re   = 1'b1;
          next_s.mem_addr = {s.vec[15:1], 1'b1}; // RULE20
          next_s.pc_val[15:8] = mem_rdata_in;
        end else begin
          next_s.pc_val[7:0] = mem_rdata_in; // RULE9
          next_s.pc_load     = 1'b1;
          next_s.cnt         = 4'h0;
          next_s.fsm         = IVE_ST_IDLE;
        end
      end
      IVE_ST_PULL: begin
        next_s.cnt = 4'(s.cnt + 4'h1);
        if (s.cnt != IVE_PULL_LAST) begin
          next_s.mem_re   = 1'b1;
          next_s.mem_addr = 16'(s.sp + {12'h000, s.cnt} + 16'h0001); // RULE10
        end
        if (s.cnt != 4'h0) begin
          if (s.cnt == 4'h1) begin
            next_s.condition_code_reg = mem_rdata_in; // RULE10
          end else begin
            next_s.restore = put_byte(s.restore, 4'(IVE_PULL_LAST - s.cnt), mem_rdata_in);
          end
        end
        if (s.cnt == IVE_PULL_LAST) begin
          next_s.restore_valid = 1'b1;
          next_s.pc_load       = 1'b1;
          next_s.pc_val        = next_s.restore.pc;
          next_s.sp            = 16'(s.sp + IVE_STACK_SPAN);
          next_s.cnt           = 4'h0;
          next_s.fsm           = IVE_ST_IDLE;
        end
      end
      default: begin
        next_s.fsm = IVE_ST_IDLE;
      end
    endcase
    // Registered so the busy output comes straight from a flop
    next_s.busy = (next_s.fsm != IVE_ST_IDLE);
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s          <= '0;
      s.fsm      <= IVE_ST_IDLE;
      s.condition_code_reg      <= IVE_CCR_RESET; // RULE22
      s.psel     <= IVE_PSEL_RESET;
      s.vec      <= IVE_VEC_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign reg_rdata_out          = s.rdata;
  assign mem_addr_out           = s.mem_addr;
  assign mem_wdata_out          = s.mem_wdata;
  assign mem_we_out             = s.mem_we;
  assign mem_re_out             = s.mem_re;
  assign busy_out               = s.busy;
  assign pc_load_out            = s.pc_load;
  assign pc_value_out           = s.pc_val;
  assign restore_valid_out      = s.restore_valid;
  assign restore_regs_out       = s.restore;
  assign sp_out                 = s.sp;
  assign condition_code_reg_out = s.condition_code_reg;
  assign receive_full_flag_out  = s.rx_full;

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  chk_x_never_set: assert property (@(posedge core_clk_in) disable iff (!nrst_in) // RULE22
    (reg_wr_in && reg_addr_in == IVE_REG_CCR && !s.condition_code_reg[IVE_CCR_X] && !wd_hit && !cm_hit)
      |=> !s.condition_code_reg[IVE_CCR_X]) else $error("X bit set by software");

  chk_stack_nine: assert property (@(posedge core_clk_in) disable iff (!nrst_in) // RULE7
    (s.fsm == IVE_ST_STACK && s.cnt == 4'h0) |=> s.mem_we [*8] ##1 s.mem_we ##1 !s.mem_we)
    else $error("Stacking is not nine writes");

  chk_ccr_last: assert property (@(posedge core_clk_in) disable iff (!nrst_in) // RULE7
    (s.fsm == IVE_ST_STACK && s.cnt == IVE_STACK_LAST)
      |=> s.mem_addr == 16'(s.sp + 16'h0001) && s.mem_wdata == $past(s.condition_code_reg))
    else $error("CONDITION_CODE_REG not stacked at SP-8");

  chk_i_after_stack: assert property (@(posedge core_clk_in) disable iff (!nrst_in) // RULE8
    (s.fsm == IVE_ST_STACK && s.cnt == IVE_STACK_LAST)
      |=> s.condition_code_reg[IVE_CCR_I] && (s.condition_code_reg[IVE_CCR_X] == ($past(s.set_x) || $past(s.condition_code_reg[IVE_CCR_X]))))
    else $error("Mask bits wrong after stacking");

  chk_vec_load: assert property (@(posedge core_clk_in) disable iff (!nrst_in) // RULE9
    (s.fsm == IVE_ST_VEC && s.cnt == 4'h0) |-> ##1 (s.mem_re && s.mem_addr == $past(s.vec))
      ##2 s.pc_load) else $error("Vector fetch timing wrong");

  chk_mask_gate: assert property (@(posedge core_clk_in) disable iff (!nrst_in) // RULE2
    (s.fsm == IVE_ST_IDLE && instr_done_in && s.condition_code_reg[IVE_CCR_I] && !return_in && !nmi_ok
      && !illegal_opcode_in && !software_trap_in && !wd_hit && !cm_hit)
      |=> s.fsm == IVE_ST_IDLE) else $error("Masked request serviced");

  chk_psel_guard: assert property (@(posedge core_clk_in) disable iff (!nrst_in) // RULE21
    (reg_wr_in && reg_addr_in == IVE_REG_PRIO && !s.condition_code_reg[IVE_CCR_I])
      |=> s.psel == $past(s.psel)) else $error("Priority changed while unmasked");

  chk_rx_clear: assert property (@(posedge core_clk_in) disable iff (!nrst_in) // RULE11
    (rx_status_rd_in[0] && s.rx_full[0] && !flags_in.sci[0].rx_full)
      ##1 (rx_data_rd_in[0] && !flags_in.sci[0].rx_full) |=> !s.rx_full[0])
    else $error("Receive-full flag not cleared");

  chk_pull_len: assert property (@(posedge core_clk_in) disable iff (!nrst_in) // RULE10
    (s.fsm == IVE_ST_PULL && s.cnt == 4'h0) |-> ##10 (s.restore_valid && s.pc_load))
    else $error("Return pull length wrong");

endmodule // ive_entry

/* hdl/ive_pkg.sv */
// Constants, vector table and carrier types for the interrupt entry unit
package ive_pkg;

  localparam int          IVE_NUM_MASKABLE = 17;
  localparam int          IVE_NUM_VECTORS  = 20;
  localparam int          IVE_NUM_SOURCES  = 32;
  localparam int          IVE_STACK_BYTES  = 9;
  localparam logic [3:0]  IVE_STACK_LAST   = 4'h8;
  localparam logic [3:0]  IVE_PULL_LAST    = 4'h9;
  localparam logic [3:0]  IVE_VEC_LAST     = 4'h2;
  localparam logic [15:0] IVE_STACK_SPAN   = 16'h0009;

  // Register offsets on the plain software port
  localparam logic [7:0]  IVE_REG_PRIO     = 8'h3c;
  localparam logic [7:0]  IVE_REG_CCR      = 8'h3d;
  localparam logic [7:0]  IVE_REG_PEND     = 8'h3e;
  localparam logic [7:0]  IVE_REG_RXFULL   = 8'h3f;

  localparam logic [4:0]  IVE_PSEL_RESET   = 5'h06;
  localparam logic [4:0]  IVE_PSEL_FIRST   = 5'h06;
  localparam logic [4:0]  IVE_PSEL_LAST    = 5'h16;
  localparam logic [7:0]  IVE_CCR_RESET    = 8'hd0;
  localparam int          IVE_CCR_X        = 6;
  localparam int          IVE_CCR_I        = 4;

  localparam logic [15:0] IVE_VEC_NMI      = 16'hfff4;
  localparam logic [15:0] IVE_VEC_SWTRAP   = 16'hfff6;
  localparam logic [15:0] IVE_VEC_ILLEGAL  = 16'hfff8;
  localparam logic [15:0] IVE_VEC_WATCHDOG = 16'hfffa;
  localparam logic [15:0] IVE_VEC_CLKMON   = 16'hfffc;
  localparam logic [15:0] IVE_VEC_RESET    = 16'hfffe;
  localparam logic [15:0] IVE_VEC_RSV_LOW  = 16'hffc0;

  // Maskable sources, indexed in priority-select code order (code - 6)
  localparam logic [15:0] IVE_VEC_TABLE [IVE_NUM_MASKABLE] = '{
    16'hfff2, 16'hfff0, 16'hffee, 16'hffec, 16'hffea, 16'hffe8, 16'hffe6, 16'hffe4,
    16'hffe2, 16'hffe0, 16'hffde, 16'hffdc, 16'hffda, 16'hffd8, 16'hffd6, 16'hffd4,
    16'hffd2};
  // Fixed default ranking, highest first
  localparam logic [4:0] IVE_DEFAULT_ORDER [IVE_NUM_MASKABLE] = '{
    5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07,
    5'h08, 5'h09, 5'h0f, 5'h10, 5'h0a, 5'h0b, 5'h0c, 5'h0d, 5'h0e};

  typedef enum logic [2:0] {
    IVE_ST_IDLE  = 3'b000,
    IVE_ST_STACK = 3'b001,
    IVE_ST_VEC   = 3'b010,
    IVE_ST_PULL  = 3'b011
  } ive_state_t;

  typedef struct packed {
    logic [15:0] pc;
    logic [15:0] iy;
    logic [15:0] ix;
    logic [7:0]  acc_a;
    logic [7:0]  acc_b;
  } ive_cpu_regs_t;

  typedef struct packed {
    logic rx_full;
    logic overrun;
    logic tx_empty;
    logic tx_complete;
    logic idle_line;
  } ive_sci_flags_t;

  typedef struct packed {
    logic receive_irq_en;
    logic tx_empty_irq_en;
    logic tx_complete_irq_en;
    logic idle_irq_en;
  } ive_sci_en_t;

  typedef struct packed {
    logic           irq_level;
    logic           periodic_tick;
    logic [2:0]     capture;
    logic [3:0]     compare;
    logic           capture4_compare5;
    logic           timer_overflow;
    logic           pulse_overflow;
    logic           pulse_edge;
    logic           sync_serial;
    ive_sci_flags_t [2:0] sci;
  } ive_flags_t;

  typedef struct packed {
    logic        periodic_tick_irq_en;
    logic        capture1_irq_en, capture2_irq_en, capture3_irq_en;
    logic        compare1_irq_en, compare2_irq_en, compare3_irq_en, compare4_irq_en;
    logic        capture4_compare5_irq_en;
    logic        timer_overflow_irq_en;
    logic        pulse_overflow_irq_en;
    logic        pulse_edge_irq_en;
    logic        sync_serial_irq_en;
    ive_sci_en_t [2:0] sci;
    logic        watchdog_disable;
    logic        clock_monitor_en;
  } ive_enables_t;

endpackage : ive_pkg

/* sim/interrupt_vector_entry_tb.sv */
// Self-checking bench for the interrupt entry unit
module interrupt_vector_entry_tb
  import ive_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0, nrst = 1'b0, nmi = 1'b0, done = 1'b0, trap = 1'b0, ill = 1'b0;
  logic wfail = 1'b0, cfail = 1'b0;
  logic ret = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, mem_we, mem_re, busy, pc_load, rvalid;
  logic [2:0] st_rd = 3'h0, dt_rd = 3'h0, rx_full;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, rdata, mem_rdata, mem_wdata, cc, d;
  logic [15:0] sp = 16'h01ff, mem_addr, pc_value, sp_o;
  ive_flags_t flags = '0;
  ive_enables_t en = '0;
  ive_cpu_regs_t regs = '{16'h1234, 16'h5678, 16'h9abc, 8'hde, 8'hf0}, rregs;
  int n_mismatch = 0, tests_run = 0;
  always #2.5 core_clk = ~core_clk;
  ive_entry i_dut (.core_clk_in(core_clk), .nrst_in(nrst), .flags_in(flags), .enables_in(en),
    .rx_status_rd_in(st_rd), .rx_data_rd_in(dt_rd), .nonmaskable_req_pin_in(nmi),
    .watchdog_fail_in(wfail), .clock_fail_in(cfail), .instr_done_in(done),
    .software_trap_in(trap), .illegal_opcode_in(ill), .return_in(ret), .cpu_regs_in(regs),
    .sp_in(sp), .mem_rdata_in(mem_rdata), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
    .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(rdata), .mem_addr_out(mem_addr),
    .mem_wdata_out(mem_wdata), .mem_we_out(mem_we), .mem_re_out(mem_re), .busy_out(busy),
    .pc_load_out(pc_load), .pc_value_out(pc_value), .restore_valid_out(rvalid),
    .restore_regs_out(rregs), .sp_out(sp_o), .condition_code_reg_out(cc),
    .receive_full_flag_out(rx_full));
  ive_mem_model i_mem (.core_clk_in(core_clk), .mem_addr_in(mem_addr), .mem_wdata_in(mem_wdata),
    .mem_we_in(mem_we), .mem_re_in(mem_re), .mem_rdata_out(mem_rdata));
  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic reg_write(input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_read(input logic [7:0] a, output logic [7:0] v);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
    v = rdata;
  endtask
  // Boundary pulse with qualifiers {return, trap, illegal}; waits up to 40 cycles for a PC load
  task automatic boundary(input logic [2:0] kind);
    @(posedge core_clk);
    done <= 1'b1;
    {ret, trap, ill} <= kind;
    @(posedge core_clk);
    done <= 1'b0;
    {ret, trap, ill} <= 3'h0;
    for (int i = 0; i < 40 && pc_load !== 1'b1; i++) @(posedge core_clk);
  endtask
  task automatic do_entry(input logic [2:0] kind, input logic [15:0] vec,
                          input logic [7:0] cc_old, input logic [7:0] cc_new);
    logic [7:0] b [9];
    b = '{regs.pc[7:0], regs.pc[15:8], regs.iy[7:0], regs.iy[15:8], regs.ix[7:0],
          regs.ix[15:8], regs.acc_a, regs.acc_b, cc_old};
    boundary(kind);
    check("vector load", pc_load, 1'b1);
    check("vector target", pc_value, {vec[7:0] ^ 8'h5a, vec[7:0] ^ 8'h5b});
    check("masks after entry", cc, cc_new);
    check("stack pointer", sp_o, 16'h01f6);
    for (int k = 0; k < 9; k++) check("stacked byte", i_mem.mem[16'h01ff - k], b[k]);
  endtask
  task automatic do_return(input logic [7:0] cc_exp);
    sp <= 16'h01f6;
    boundary(3'b100);
    check("restore valid", rvalid, 1'b1);
    check("restored regs", rregs[15:0], regs[15:0]);
    check("restored pc", pc_value, regs.pc);
    check("restored masks", cc, cc_exp);
    check("restored sp", sp_o, 16'h01ff);
    sp <= 16'h01ff;
  endtask
  task automatic no_entry();
    boundary(3'b000);
    check("no entry", pc_load, 1'b0);
    check("idle", busy, 1'b0);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_regs();
    reg_read(IVE_REG_CCR, d);
    check("masks at reset", d, IVE_CCR_RESET);
    reg_read(IVE_REG_PRIO, d);
    check("select at reset", d, {3'h0, IVE_PSEL_RESET});
    reg_read(8'h10, d);
    check("unmapped read", d, 8'h00);
  endtask
  task automatic t_promote();
    reg_write(IVE_REG_PRIO, 8'h10);
    reg_write(IVE_REG_CCR, 8'h00);
    reg_write(IVE_REG_CCR, 8'h40);
    reg_write(IVE_REG_PRIO, 8'h06);
    reg_read(IVE_REG_CCR, d);
    check("mask not re-set", d, 8'h00);
    reg_read(IVE_REG_PRIO, d);
    check("select locked", d, 8'h10);
    flags.irq_level <= 1'b1;
    flags.timer_overflow <= 1'b1;
    en.timer_overflow_irq_en <= 1'b1;
    reg_read(IVE_REG_PEND, d);
    check("pending winner", d, 8'h8a);
    do_entry(3'b000, 16'hffde, 8'h00, 8'h10);
    do_return(8'h00);
    flags <= '0;
    en.timer_overflow_irq_en <= 1'b0;
  endtask
  task automatic t_mask();
    flags.timer_overflow <= 1'b1;
    no_entry();
    flags.irq_level <= 1'b1;
    do_entry(3'b000, 16'hfff2, 8'h00, 8'h10);
    no_entry();
    flags <= '0;
  endtask
  task automatic t_nonmaskable();
    nmi <= 1'b1;
    do_entry(3'b000, IVE_VEC_NMI, 8'h10, 8'h50);
    nmi <= 1'b0;
    do_return(8'h10);
    do_entry(3'b010, IVE_VEC_SWTRAP, 8'h10, 8'h10);
    do_entry(3'b001, IVE_VEC_ILLEGAL, 8'h10, 8'h10);
  endtask
  task automatic t_rx_full();
    @(posedge core_clk);
    flags.sci[0].rx_full <= 1'b1;
    @(posedge core_clk);
    flags.sci[0].rx_full <= 1'b0;
    dt_rd <= 3'h1;
    @(posedge core_clk);
    dt_rd <= 3'h0;
    st_rd <= 3'h1;
    @(posedge core_clk);
    check("full kept", rx_full, 3'h1);
    st_rd <= 3'h0;
    dt_rd <= 3'h1;
    @(posedge core_clk);
    dt_rd <= 3'h0;
    @(posedge core_clk);
    check("full cleared", rx_full, 3'h0);
  endtask
  // Failures are held one cycle only, else they re-enter at once
  task automatic t_reset_type();
    en.watchdog_disable <= 1'b1;
    {wfail, cfail} <= 2'b11;
    no_entry();
    en.clock_monitor_en <= 1'b1;
    @(posedge core_clk);
    cfail <= 1'b0;
    boundary(3'b000);
    check("clock monitor target", pc_value,
          {IVE_VEC_CLKMON[7:0] ^ 8'h5a, IVE_VEC_CLKMON[7:0] ^ 8'h5b});
    check("masks after clock fail", cc, 8'h50);
    en.watchdog_disable <= 1'b0;
    @(posedge core_clk);
    wfail <= 1'b0;
    boundary(3'b000);
    check("watchdog target", pc_value,
          {IVE_VEC_WATCHDOG[7:0] ^ 8'h5a, IVE_VEC_WATCHDOG[7:0] ^ 8'h5b});
    check("masks after watchdog", cc, 8'h50);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge core_clk);
    nrst <= 1'b1;
    t_reset_regs();
    t_promote();
    t_mask();
    t_nonmaskable();
    t_rx_full();
    t_reset_type();
    stop_test();
  end
  // Whole sequence needs under two microseconds
  initial begin
    #20us;
    n_mismatch++;
    stop_test();
  end
endmodule // interrupt_vector_entry_tb

/* sim/ive_mem_model.sv */
// Memory partner: stack RAM and vector table seen by the entry unit
module ive_mem_model
  import ive_pkg::*;
(
  input  wire logic        core_clk_in,
  input  wire logic [15:0] mem_addr_in,
  input  wire logic [7:0]  mem_wdata_in,
  input  wire logic        mem_we_in,
  input  wire logic        mem_re_in,
  output logic [7:0]       mem_rdata_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [logic [15:0]];
  // Unwritten bytes hold an address pattern; high vector byte sits at the even address
  function automatic logic [7:0] rd(input logic [15:0] a);
    return mem.exists(a) ? mem[a] : (a[7:0] ^ 8'h5a);
  endfunction
  always @(posedge core_clk_in) begin
    if (mem_we_in) begin
      mem[mem_addr_in] = mem_wdata_in;
    end
  end
  // Read data follow the address in the same cycle; idle shows the inverse
  always @(mem_re_in or mem_addr_in) begin
    mem_rdata_out = mem_re_in ? rd(mem_addr_in) : ~rd(mem_addr_in);
  end
endmodule // ive_mem_model
